// ---- rtc_bank_pkg.sv ----
package rtc_bank_pkg;

  // Register offsets
  localparam logic [7:0] OFF_CONTROL_CONFIG = 8'h0E;
  localparam logic [7:0] OFF_STATUS_FLAGS = 8'h0F;
  localparam logic [7:0] OFF_FREQ_TRIM_OFFSET = 8'h10;
  localparam logic [7:0] OFF_TEMP_INTEGER = 8'h11;
  localparam logic [7:0] OFF_TEMP_FRACTION = 8'h12;

  // Control field positions
  localparam int CTL_OSC_STOP_BIT = 7;
  localparam int CTL_BATTERY_SQUARE_WAVE_ENABLE_BIT = 6;
  localparam int CTL_TEMP_CONVERT_REQUEST_BIT = 5;
  localparam int CTL_NA_HI_BIT = 4;
  localparam int CTL_NA_LO_BIT = 3;
  localparam int CTL_INTSEL_BIT = 2;
  localparam int CTL_ALARM_TWO_IRQ_ENABLE_BIT = 1;
  localparam int CTL_ALARM_ONE_IRQ_ENABLE_BIT = 0;

  // Status field positions
  localparam int STS_OSF_BIT = 7;
  localparam int STS_KHZ_EN_BIT = 3;
  localparam int STS_BUSY_BIT = 2;
  localparam int STS_A2F_BIT = 1;
  localparam int STS_A1F_BIT = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h1C;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [9:0] TEMP_ZERO_CODE = 10'h000;

  // Measurement schedule, in seconds
  localparam logic [3:0] MEAS_PERIOD_MAIN = 4'h1;
  localparam logic [3:0] MEAS_PERIOD_BATTERY = 4'hA;

  // Oscillator edges per second; khz output toggles on each edge
  localparam int OSC_EDGES_PER_SEC = 65536;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic done;
    logic [9:0] code;
  } sensor_result_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_COMPENSATE = 3'b100
  } temp_convert_request_state_t;

endpackage

// ---- rtc_control_status_bank.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Enable bit 1 stops oscillator on battery
// - Main supply keeps oscillator always running
// - Stopped oscillator freezes second ticks, alarm flags and new conversions
// - Battery square wave enable keeps 1Hz
// - Convert bit starts conversion, self-clears after
// - Compensation at most once per second
// - Control bits 4:3 stored, no effect
// - Interrupt select chooses 1Hz or alarms
// - Alarm flags set regardless of select
// - Alarm two interrupt needs enable and select
// - Alarm one interrupt needs enable and select
// - Control powers up to defined defaults
// - Oscillator halted flag sticky until written 0
// - Status bits 6:4 read zero
// - khz_clock_out output floats when disabled; default on
// - Busy set at sensor request, cleared done
// - Alarm flags cleared by writing 0 only
// - Aging offset signed, added to trim
// - Temperature 10-bit signed, quarter degrees
// - Reset loads 0 degrees, starts conversion
// - Measure on power-up, battery access, periodically
// - Temperature refreshed per conversion, read only
// - Alarms checked only at once-per-second update
module rtc_control_status_bank
  import rtc_bank_pkg::*;
#(
  parameter int OSC_TICKS_PER_SEC = OSC_EDGES_PER_SEC
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Oscillator clock
  input wire logic osc_clk,
  // Register access from serial engine
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Supply monitor pin, high while main supply below power-fail
  input wire logic below_power_fail,
  // Alarm compare results
  input wire logic alarm_one_match,
  input wire logic alarm_two_match,
  // Temperature sensor
  output logic sensor_start,
  input wire sensor_result_t sensor_result,
  // Compensation engine
  output logic comp_update,
  input wire logic [7:0] factory_trim,
  output logic [8:0] trim_word,
  // Oscillator run control and once-per-second time update
  output logic osc_run,
  output logic second_tick,
  // Shared interrupt / square wave pin, open drain
  output logic irq_or_square_wave_out,
  output logic irq_or_square_wave_oe,
  // khz_clock_out pin
  output logic khz_clock_out,
  output logic khz_clock_oe
);

  function automatic logic is_write(reg_req_t r, logic [7:0] off);
    return r.wr && (r.addr == off);
  endfunction

  // Supply level comes from an analog pin
  logic pf_meta_q;
  logic on_battery_q;
  always_ff @(posedge sys_clk) begin
    pf_meta_q <= below_power_fail;
    on_battery_q <= pf_meta_q;
  end

  // Control register
  logic [7:0] control_q;
  logic temp_convert_request_busy_q;
  logic temp_convert_request_done_user;
  logic user_pending;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      control_q <= CONTROL_RESET;
    end else begin
      if (is_write(reg_req, OFF_CONTROL_CONFIG)) begin
        // Bits 4:3 are kept for read back only
        control_q[7:6] <= reg_req.wdata[7:6];
        control_q[4:0] <= reg_req.wdata[4:0];
      end
      // Writing 1 latches; a write of 0 cannot abort it
      if (is_write(reg_req, OFF_CONTROL_CONFIG) &&
          reg_req.wdata[CTL_TEMP_CONVERT_REQUEST_BIT]) begin
        control_q[CTL_TEMP_CONVERT_REQUEST_BIT] <= 1'b1;
      end else if (temp_convert_request_done_user) begin
        control_q[CTL_TEMP_CONVERT_REQUEST_BIT] <= 1'b0;
      end
    end
  end

  logic osc_stop_on_battery_bit;
  logic battery_square_wave_enable;
  logic temp_convert_request;
  logic irq_output_select;
  logic alarm_two_irq_enable;
  logic alarm_one_irq_enable;
  assign osc_stop_on_battery_bit = control_q[CTL_OSC_STOP_BIT];
  assign battery_square_wave_enable = control_q[CTL_BATTERY_SQUARE_WAVE_ENABLE_BIT];
  assign temp_convert_request = control_q[CTL_TEMP_CONVERT_REQUEST_BIT];
  assign irq_output_select = control_q[CTL_INTSEL_BIT];
  assign alarm_two_irq_enable = control_q[CTL_ALARM_TWO_IRQ_ENABLE_BIT];
  assign alarm_one_irq_enable = control_q[CTL_ALARM_ONE_IRQ_ENABLE_BIT];

  // Oscillator enable
  logic osc_run_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      osc_run_q <= 1'b1;
    end else begin
      osc_run_q <= !(on_battery_q && osc_stop_on_battery_bit);
    end
  end
  assign osc_run = osc_run_q;

  // Oscillator domain
  logic osc_rst_meta_q;
  logic osc_rst_n_q;
  logic osc_en_meta_q;
  logic osc_en_q;
  logic khz_en_meta_q;
  logic khz_en_q;
  logic khz_enable_q;
  logic [31:0] osc_cnt_q;
  logic sec_toggle_q;
  logic half_sec_q;
  logic khz_q;
  logic khz_oe_q;

  always_ff @(posedge osc_clk) begin
    osc_rst_meta_q <= rst_n;
    osc_rst_n_q <= osc_rst_meta_q;
    osc_en_meta_q <= osc_run_q;
    osc_en_q <= osc_en_meta_q;
    khz_en_meta_q <= khz_enable_q;
    khz_en_q <= khz_en_meta_q;
  end

  always_ff @(posedge osc_clk) begin
    if (!osc_rst_n_q) begin
      osc_cnt_q <= 32'h0000_0000;
      sec_toggle_q <= 1'b0;
      half_sec_q <= 1'b0;
    end else if (osc_en_q) begin
      if (osc_cnt_q == 32'(OSC_TICKS_PER_SEC - 1)) begin
        osc_cnt_q <= 32'h0000_0000;
        sec_toggle_q <= !sec_toggle_q;
      end else begin
        osc_cnt_q <= osc_cnt_q + 32'h0000_0001;
      end
      half_sec_q <= (osc_cnt_q >= 32'(OSC_TICKS_PER_SEC / 2));
    end
  end

  always_ff @(posedge osc_clk) begin
    if (!osc_rst_n_q) begin
      khz_q <= 1'b0;
      khz_oe_q <= 1'b0;
    end else begin
      khz_q <= osc_en_q ? !khz_q : 1'b0;
      khz_oe_q <= khz_en_q;
    end
  end
  assign khz_clock_out = khz_q;
  assign khz_clock_oe = khz_oe_q;

  // Second tick and 1Hz level back into system domain
  logic tick_meta_q;
  logic tick_sync_q;
  logic tick_seen_q;
  logic sq_meta_q;
  logic sq_q;
  logic tick_q;
  always_ff @(posedge sys_clk) begin
    tick_meta_q <= sec_toggle_q;
    tick_sync_q <= tick_meta_q;
    sq_meta_q <= half_sec_q;
    sq_q <= sq_meta_q;
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_seen_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      tick_seen_q <= tick_sync_q;
      // Gated so nothing updates while stopped
      tick_q <= (tick_sync_q != tick_seen_q) && osc_run_q;
    end
  end
  assign second_tick = tick_q;

  // Status register
  logic osf_q;
  logic alarm_one_flag_q;
  logic alarm_two_flag_q;
  logic osc_run_prev_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      osf_q <= 1'b1;
      khz_enable_q <= 1'b1;
      osc_run_prev_q <= 1'b1;
    end else begin
      osc_run_prev_q <= osc_run_q;
      // Stop event wins over a clearing write
      if (osc_run_prev_q && !osc_run_q) begin
        osf_q <= 1'b1;
      end else if (is_write(reg_req, OFF_STATUS_FLAGS) &&
                   !reg_req.wdata[STS_OSF_BIT]) begin
        osf_q <= 1'b0;
      end
      if (is_write(reg_req, OFF_STATUS_FLAGS)) begin
        khz_enable_q <= reg_req.wdata[STS_KHZ_EN_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alarm_one_flag_q <= 1'b0;
      alarm_two_flag_q <= 1'b0;
    end else begin
      // Match sampled only on the second update
      if (tick_q && alarm_one_match) begin
        alarm_one_flag_q <= 1'b1;
      end else if (is_write(reg_req, OFF_STATUS_FLAGS) &&
                   !reg_req.wdata[STS_A1F_BIT]) begin
        alarm_one_flag_q <= 1'b0;
      end
      if (tick_q && alarm_two_match) begin
        alarm_two_flag_q <= 1'b1;
      end else if (is_write(reg_req, OFF_STATUS_FLAGS) &&
                   !reg_req.wdata[STS_A2F_BIT]) begin
        alarm_two_flag_q <= 1'b0;
      end
    end
  end

  // Aging offset
  logic [7:0] trim_offset_q;
  logic [8:0] trim_word_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trim_offset_q <= TRIM_RESET;
      trim_word_q <= 9'h000;
    end else begin
      if (is_write(reg_req, OFF_FREQ_TRIM_OFFSET)) begin
        trim_offset_q <= reg_req.wdata;
      end
      // Signed offset on unsigned factory trim
      trim_word_q <= {1'b0, factory_trim} +
                     {trim_offset_q[7], trim_offset_q};
    end
  end
  assign trim_word = trim_word_q;

  // Measurement schedule
  logic [3:0] sec_cnt_q;
  logic periodic_pending_q;
  logic access_pending_q;
  logic [3:0] meas_period;
  assign meas_period = on_battery_q ? MEAS_PERIOD_BATTERY : MEAS_PERIOD_MAIN;
  logic period_end;
  assign period_end = sec_cnt_q + 4'h1 >= meas_period;

  temp_convert_request_state_t state_q;
  logic start_now;
  logic user_active_q;
  logic comp_done_sec_q;
  logic comp_q;
  assign start_now = (state_q == ST_IDLE) && osc_run_q &&
                     (temp_convert_request || periodic_pending_q ||
                      access_pending_q);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sec_cnt_q <= 4'h0;
      periodic_pending_q <= 1'b1;
      access_pending_q <= 1'b0;
    end else begin
      // Own counter, untouched by user requests
      if (tick_q) begin
        sec_cnt_q <= period_end ? 4'h0 : sec_cnt_q + 4'h1;
      end
      // A period end in a tick cycle keeps the request pending over a start
      if (tick_q && period_end) begin
        periodic_pending_q <= 1'b1;
      end else if (start_now && !user_pending) begin
        periodic_pending_q <= 1'b0;
      end
      if ((reg_req.wr || reg_req.rd) && on_battery_q) begin
        access_pending_q <= 1'b1;
      end else if (start_now && !user_pending) begin
        access_pending_q <= 1'b0;
      end
    end
  end
  // User request served alone only when no scheduled one waits
  assign user_pending = temp_convert_request && !periodic_pending_q &&
                        !access_pending_q;

  // Conversion sequencer
  logic [9:0] temp_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      temp_convert_request_busy_q <= 1'b0;
      user_active_q <= 1'b0;
      comp_done_sec_q <= 1'b0;
      comp_q <= 1'b0;
      temp_q <= TEMP_ZERO_CODE;
    end else begin
      comp_q <= 1'b0;
      if (tick_q) begin
        comp_done_sec_q <= 1'b0;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (start_now) begin
            state_q <= ST_CONVERT;
            temp_convert_request_busy_q <= 1'b1;
            user_active_q <= temp_convert_request;
          end
        end
        ST_CONVERT: begin
          if (sensor_result.done) begin
            temp_q <= sensor_result.code;
            temp_convert_request_busy_q <= 1'b0;
            state_q <= ST_COMPENSATE;
          end
        end
        ST_COMPENSATE: begin
          // Skipped if already run this second
          if (!comp_done_sec_q) begin
            comp_q <= 1'b1;
            comp_done_sec_q <= 1'b1;
          end
          user_active_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  assign temp_convert_request_done_user = (state_q == ST_CONVERT) && sensor_result.done &&
                          user_active_q;
  assign sensor_start = (state_q == ST_IDLE) && start_now;
  assign comp_update = comp_q;

  // Shared interrupt / square wave pin, low or released
  logic pin_drive_q;
  logic alarm_irq;
  assign alarm_irq = (alarm_one_flag_q && alarm_one_irq_enable) ||
                     (alarm_two_flag_q && alarm_two_irq_enable);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_drive_q <= 1'b0;
    end else if (irq_output_select) begin
      pin_drive_q <= alarm_irq;
    end else if (on_battery_q && !battery_square_wave_enable) begin
      pin_drive_q <= 1'b0;
    end else begin
      pin_drive_q <= osc_run_q && sq_q;
    end
  end
  assign irq_or_square_wave_out = 1'b0;
  assign irq_or_square_wave_oe = pin_drive_q;

  // Register read, zero for unmapped offsets
  logic [7:0] rdata_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFF_CONTROL_CONFIG: rdata_q <= control_q;
        OFF_STATUS_FLAGS: rdata_q <= {osf_q, 3'b000, khz_enable_q,
                                      temp_convert_request_busy_q, alarm_two_flag_q,
                                      alarm_one_flag_q};
        OFF_FREQ_TRIM_OFFSET: rdata_q <= trim_offset_q;
        OFF_TEMP_INTEGER: rdata_q <= temp_q[9:2];
        OFF_TEMP_FRACTION: rdata_q <= {temp_q[1:0], 6'b00_0000};
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

endmodule

// ---- rtc_bank_props.sv ----
`timescale 1ns/1ps
module rtc_bank_props
  import rtc_bank_pkg::*;
#(
  parameter int OSC_TICKS_PER_SEC = OSC_EDGES_PER_SEC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register side
  input wire reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic below_power_fail,
  // Sensor and trim
  input wire logic sensor_start,
  input wire sensor_result_t sensor_result,
  input wire logic comp_update,
  input wire logic [7:0] factory_trim,
  input wire logic [8:0] trim_word,
  // Oscillator and pins
  input wire logic osc_run,
  input wire logic second_tick,
  input wire logic irq_or_square_wave_out,
  input wire logic irq_or_square_wave_oe
);
  logic [7:0] ctl_q;
  logic [7:0] age_q;
  logic [7:0] ft_q;
  logic [1:0] ctl_cnt_q;
  logic [1:0] trim_cnt_q;
  logic comp_seen_q;
  logic wr_ctl;
  logic wr_age;
  assign wr_ctl = reg_req.wr && reg_req.addr == OFF_CONTROL_CONFIG;
  assign wr_age = reg_req.wr && reg_req.addr == OFF_FREQ_TRIM_OFFSET;

  // Shadow copies settle for a few cycles before outputs are judged
  always_ff @(posedge sys_clk) begin
    if (!rst_n || wr_ctl) begin
      ctl_cnt_q <= 2'h0;
    end else if (ctl_cnt_q != 2'h3) begin
      ctl_cnt_q <= ctl_cnt_q + 2'h1;
    end
    if (!rst_n) begin
      ctl_q <= CONTROL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    ft_q <= factory_trim;
    if (!rst_n || wr_age || factory_trim != ft_q) begin
      trim_cnt_q <= 2'h0;
    end else if (trim_cnt_q != 2'h3) begin
      trim_cnt_q <= trim_cnt_q + 2'h1;
    end
    if (!rst_n) begin
      age_q <= TRIM_RESET;
    end else if (wr_age) begin
      age_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || second_tick) begin
      comp_seen_q <= 1'b0;
    end else if (comp_update) begin
      comp_seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_START_SINGLE: assert property (sensor_start |=> !sensor_start)
    else $error("sensor start longer than one cycle");
  AST_START_RUNNING: assert property (sensor_start |-> osc_run)
    else $error("conversion started with oscillator stopped");
  AST_COMP_AFTER_DONE: assert property (comp_update |->
    $past(sensor_result.done) || $past(sensor_result.done, 2))
    else $error("compensation without finished conversion");
  AST_COMP_ONCE: assert property (comp_update |-> !comp_seen_q)
    else $error("second compensation within one second");
  AST_OSC_MAIN: assert property ((!below_power_fail)[*5] |-> osc_run)
    else $error("oscillator stopped on main supply");
  AST_TICK_FROZEN: assert property ((!osc_run)[*8] |-> !second_tick)
    else $error("time update while oscillator stopped");
  AST_STATUS_ZERO: assert property ($past(reg_req.rd) &&
    $past(reg_req.addr) == OFF_STATUS_FLAGS |-> reg_rdata[6:4] == 3'h0)
    else $error("status unused bits not zero");
  AST_FRAC_ZERO: assert property ($past(reg_req.rd) &&
    $past(reg_req.addr) == OFF_TEMP_FRACTION |-> reg_rdata[5:0] == 6'h00)
    else $error("fraction low bits not zero");
  AST_IRQ_GATED: assert property (ctl_cnt_q == 2'h3 &&
    ctl_q[2] && ctl_q[1:0] == 2'h0 |-> !irq_or_square_wave_oe)
    else $error("interrupt with alarms disabled");
  AST_OPEN_DRAIN: assert property (irq_or_square_wave_out == 1'b0)
    else $error("interrupt pin driven high");
  AST_TRIM_SUM: assert property (trim_cnt_q == 2'h3 |->
    trim_word == {1'b0, ft_q} + {age_q[7], age_q})
    else $error("trim word not trim plus signed offset");

  CV_COMP: cover property (comp_update);
  CV_IRQ: cover property (irq_or_square_wave_oe && ctl_q[2]);
  CV_STOP: cover property ($fell(osc_run));
endmodule

// ---- temp_sensor_model.sv ----
`timescale 1ns/1ps
module temp_sensor_model
  import rtc_bank_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Conversion handshake
  input wire logic sensor_start,
  input wire logic slow,
  input wire logic [9:0] code,
  output sensor_result_t sensor_result
);
  logic [5:0] left_q;
  // Code toggles outside done so stale data never looks valid
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      left_q <= 6'h00;
      sensor_result <= '0;
    end else begin
      sensor_result.done <= left_q == 6'h01;
      sensor_result.code <= left_q == 6'h01 ? code : ~sensor_result.code;
      if (left_q != 6'h00) begin
        left_q <= left_q - 6'h01;
      end else if (sensor_start) begin
        left_q <= slow ? 6'h1E : 6'h03;
      end
    end
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  import rtc_bank_pkg::*;
  logic sys_clk = 0, osc_clk = 0, rst_n = 0, bpf = 0, a1 = 0, a2 = 0;
  logic slow = 1, started = 0, oe_prev = 0, s_start, comp, run, tick;
  logic irq_o, irq_oe, khz, khz_oe, khz_prev = 0;
  reg_req_t req = '0;
  sensor_result_t sres;
  logic [9:0] code = 10'h064;
  logic [7:0] ft = 8'h00, d, ag;
  logic [8:0] trim;
  int bad_count = 0, cmp_count = 0, oe_chg = 0, khz_chg = 0, seed, n;
  logic [7:0] d_out;

  rtc_control_status_bank #(.OSC_TICKS_PER_SEC(16)) uut (.sys_clk(sys_clk),
    .rst_n(rst_n), .osc_clk(osc_clk), .reg_req(req), .reg_rdata(d_out),
    .below_power_fail(bpf), .alarm_one_match(a1), .alarm_two_match(a2),
    .sensor_start(s_start), .sensor_result(sres), .comp_update(comp),
    .factory_trim(ft), .trim_word(trim), .osc_run(run), .second_tick(tick),
    .irq_or_square_wave_out(irq_o), .irq_or_square_wave_oe(irq_oe),
    .khz_clock_out(khz), .khz_clock_oe(khz_oe));
  temp_sensor_model sensor (.sys_clk(sys_clk), .rst_n(rst_n),
    .sensor_start(s_start), .slow(slow), .code(code), .sensor_result(sres));

  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #6 osc_clk = ~osc_clk;
  end
  always @(posedge sys_clk) begin
    started = started | (s_start === 1'b1);
    oe_chg = oe_chg + (irq_oe !== oe_prev);
    oe_prev = irq_oe;
    khz_chg = khz_chg + (khz !== khz_prev);
    khz_prev = khz;
  end

  function automatic logic [8:0] exp_trim(input logic [7:0] f, a);
    return {1'b0, f} + {a[7], a};
  endfunction
  task automatic wr(input logic [7:0] a, v);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    req <= '0;
    @(posedge sys_clk);
    d = d_out;
  endtask
  task automatic secs(input int s);
    // Slightly over one oscillator second, kept on the system edge
    repeat (s * 20) @(posedge sys_clk);
  endtask
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    conclude();
  end

  initial begin
    seed = $urandom(32'hee09);
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFF_TEMP_INTEGER);
    `CHK("temp_int", 8'h00, d)
    `CHK("start", 1'b1, started)
    rd(OFF_CONTROL_CONFIG);
    `CHK("ctl", 8'h1C, d)
    rd(OFF_STATUS_FLAGS);
    `CHK("status", 8'h88, d & 8'hFB)
    `CHK("busy_on", 1'b1, d[STS_BUSY_BIT])
    rd(OFF_FREQ_TRIM_OFFSET);
    `CHK("aging", 8'h00, d)
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CONTROL_CONFIG, {3'h0, i[1:0], 3'h4});
      rd(OFF_CONTROL_CONFIG);
      `CHK("ctl_na", {3'h0, i[1:0], 3'h4}, d)
    end
    for (int k = 0; k < 3; k++) begin
      code <= 10'($urandom);
      slow <= k[0];
      wr(OFF_CONTROL_CONFIG, 8'h3C);
      for (n = 0; n < 100; n++) begin
        rd(OFF_CONTROL_CONFIG);
        if (d[CTL_TEMP_CONVERT_REQUEST_BIT] !== 1'b1) break;
      end
      `CHK("temp_convert_request", 1'b0, d[CTL_TEMP_CONVERT_REQUEST_BIT])
      rd(OFF_TEMP_INTEGER);
      `CHK("temp_int", code[9:2], d)
      rd(OFF_TEMP_FRACTION);
      `CHK("temp_frac", {code[1:0], 6'h00}, d)
      wr(OFF_TEMP_INTEGER, ~code[9:2]);
      rd(OFF_TEMP_INTEGER);
      `CHK("temp_ro", code[9:2], d)
    end
    wr(OFF_STATUS_FLAGS, 8'h78);
    rd(OFF_STATUS_FLAGS);
    `CHK("status_wr", 8'h08, d & 8'hFB)
    rd(8'h20);
    `CHK("unmapped", 8'h00, d)
    wr(OFF_STATUS_FLAGS, 8'h00);
    repeat (10) @(posedge sys_clk);
    `CHK("khz_off", 1'b0, khz_oe)
    wr(OFF_STATUS_FLAGS, 8'h08);
    repeat (10) @(posedge sys_clk);
    `CHK("khz_on", 1'b1, khz_oe)
    khz_chg = 0;
    repeat (10) @(posedge sys_clk);
    `CHK("khz_run", 1'b1, khz_chg > 4)
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CONTROL_CONFIG, 8'h04 | (8'h01 << k));
      a1 <= k == 0;
      a2 <= k == 1;
      secs(2);
      a1 <= 1'b0;
      a2 <= 1'b0;
      repeat (5) @(posedge sys_clk);
      `CHK("irq_on", 1'b1, irq_oe)
      wr(OFF_STATUS_FLAGS, 8'h0B);
      rd(OFF_STATUS_FLAGS);
      `CHK("flag_keep", 1'b1, d[k])
      wr(OFF_CONTROL_CONFIG, 8'h04);
      repeat (5) @(posedge sys_clk);
      `CHK("irq_off", 1'b0, irq_oe)
      wr(OFF_STATUS_FLAGS, 8'h08);
      rd(OFF_STATUS_FLAGS);
      `CHK("flag_clr", 2'h0, d[1:0])
    end
    wr(OFF_CONTROL_CONFIG, 8'h00);
    a1 <= 1'b1;
    oe_chg = 0;
    secs(3);
    a1 <= 1'b0;
    `CHK("sqw", 1'b1, oe_chg > 2)
    rd(OFF_STATUS_FLAGS);
    `CHK("flag_sel0", 1'b1, d[0])
    for (int k = 0; k < 4; k++) begin
      ft <= 8'($urandom);
      ag = k == 0 ? 8'h80 : (k == 1 ? 8'h7F : 8'($urandom));
      wr(OFF_FREQ_TRIM_OFFSET, ag);
      repeat (4) @(posedge sys_clk);
      `CHK("trim", exp_trim(ft, ag), trim)
    end
    wr(OFF_CONTROL_CONFIG, 8'h40);
    bpf <= 1'b1;
    oe_chg = 0;
    secs(3);
    `CHK("bat_sqw", 1'b1, oe_chg > 2)
    wr(OFF_CONTROL_CONFIG, 8'h00);
    repeat (5) @(posedge sys_clk);
    oe_chg = 0;
    secs(3);
    `CHK("bat_float", 1'b0, oe_chg > 0 || irq_oe)
    wr(OFF_CONTROL_CONFIG, 8'h9C);
    repeat (10) @(posedge sys_clk);
    `CHK("osc_stop", 1'b0, run)
    `CHK("khz_stop", 1'b0, khz)
    code <= ~code;
    rd(OFF_STATUS_FLAGS);
    `CHK("osf", 1'b1, d[STS_OSF_BIT])
    `CHK("busy_idle", 1'b0, d[STS_BUSY_BIT])
    rd(OFF_TEMP_INTEGER);
    `CHK("frozen", ~code[9:2], d)
    bpf <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK("osc_main", 1'b1, run)
    conclude();
  end
endmodule

bind rtc_control_status_bank rtc_bank_props #(
  .OSC_TICKS_PER_SEC(OSC_TICKS_PER_SEC)
) props (.sys_clk, .rst_n, .reg_req, .reg_rdata, .below_power_fail,
  .sensor_start, .sensor_result, .comp_update, .factory_trim, .trim_word,
  .osc_run, .second_tick, .irq_or_square_wave_out, .irq_or_square_wave_oe);
